// ===== bench/sensor_cfg_assertions.sv
/* port checker for the sensor config bank
   bound to the top module, one sys_clk domain */
`timescale 1ns/1ps
module sensor_cfg_assertions #(
    parameter int unsigned COMMIT_CYCLES = 50
) (
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic       cs_n,
    input wire logic [7:0] field_mt,
    input wire logic       miso_oe,
    input wire logic [7:0] bias_trim,
    input wire logic [2:0] pole_pair_count,
    input wire logic       field_too_high_flag,
    input wire logic       field_too_low_flag,
    input wire logic       commit_busy,
    input wire logic       config_ready
);
    int unsigned busy_len;
    // cycles of the running commit
    always_ff @(posedge sys_clk) begin
        busy_len <= commit_busy ? busy_len + 1 : 0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    chk_ready_reload: assert property ($fell(srst) |-> ##[9:12] config_ready)
        else $error("config ready late");
    chk_commit_span: assert property ($fell(commit_busy) |-> busy_len >= COMMIT_CYCLES
        && busy_len <= COMMIT_CYCLES + 2) else $error("commit length off");
    chk_hold_busy: assert property (commit_busy && $past(commit_busy)
        |-> $stable(bias_trim) && $stable(pole_pair_count)) else $error("config moved mid commit");
    chk_cfg_source: assert property ($changed(bias_trim)
        |-> $past(commit_busy, 2) || !$past(config_ready)) else $error("config changed without commit");
    chk_oe_select: assert property ($fell(cs_n) |-> ##[1:5] miso_oe)
        else $error("output not enabled");
    chk_oe_idle: assert property (cs_n [*6] |-> !miso_oe)
        else $error("output enabled while idle");
    chk_weak_field: assert property ((field_mt < 8'h14) [*4] |-> !field_too_high_flag)
        else $error("high flag on weak field");
    chk_strong_field: assert property ((field_mt > 8'h7e) [*4] |-> !field_too_low_flag)
        else $error("low flag on strong field");
    cover property ($fell(commit_busy));
    cover property ($rose(field_too_high_flag));
    cover property ($rose(miso_oe));
endmodule
bind angle_sensor_config_regs sensor_cfg_assertions #(.COMMIT_CYCLES(COMMIT_CYCLES)) sensor_cfg_assertions_inst (
    .sys_clk, .srst, .cs_n, .field_mt, .miso_oe, .bias_trim, .pole_pair_count,
    .field_too_high_flag, .field_too_low_flag, .commit_busy, .config_ready);

// ===== bench/spi_master_model.sv
/* serial master model for the sensor bank
   steps on sys_clk, half link period is 4 clocks (800 ns period) */
`timescale 1ns/1ps
module spi_master_model (
    input  wire logic sys_clk,
    input  wire logic miso,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // link clock toggles only inside frames; its idle level is set one clock before select
    task automatic frame(input logic [15:0] cmd, input logic idle_hi, output logic [16:0] rsp);
        sclk <= idle_hi;
        @(posedge sys_clk);
        cs_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        for (int i = 16; i >= 0; i--) begin
            sclk <= 1'b0;
            mosi <= (i > 0) ? cmd[i-1] : 1'b0; // msb first
            repeat (4) @(posedge sys_clk);
            sclk <= 1'b1; // seventeenth clock fetches parity
            rsp[i] = miso;
            repeat (4) @(posedge sys_clk);
        end
        sclk <= idle_hi;
        repeat (4) @(posedge sys_clk);
        cs_n <= 1'b1;
        mosi <= ~mosi; // released line must not hold its last bit
        repeat (8) @(posedge sys_clk);
    endtask
endmodule

// ===== bench/tb_top.sv
/* self-checking bench for the sensor config bank
   master model drives the link, commit count cut to 50 */
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned COMMIT = 50;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        factory_erase = 1'b1;
    logic [15:0] raw_angle = 16'h1234;
    logic [7:0]  field_mt = 8'h00;
    logic        sclk, cs_n, mosi, miso, miso_oe, trim_x_enable, trim_y_enable;
    logic        field_too_high_flag, field_too_low_flag, commit_busy, config_ready;
    logic [7:0]  bias_trim, pulses_per_turn;
    logic [3:0]  index_shape;
    logic [2:0]  pole_pair_count;
    logic [16:0] rsp;
    int          n_errors = 0;
    int          n_compared = 0;
    // rows: address, default, written, read back
    logic [4:0]  row_addr [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h09, 5'h08};
    logic [7:0]  row_dflt [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h3f, 8'h1c, 8'h00, 8'h00, 8'h00};
    logic [7:0]  row_data [10] = '{8'hc7, 8'hf1, 8'ha5, 8'hff, 8'h5b, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0]  row_back [10] = '{8'hc7, 8'hf1, 8'ha5, 8'h03, 8'h58, 8'h3f, 8'hfc, 8'he0, 8'h80, 8'h00};
    `define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
        $display("wrong value %0t got %h exp %h", $time, g, e); end end
    always #50 sys_clk = ~sys_clk;
    angle_sensor_config_regs #(.COMMIT_CYCLES(COMMIT)) angle_sensor_config_regs_inst (
        .sys_clk, .srst, .sclk, .cs_n, .mosi, .factory_erase, .raw_angle, .field_mt, .miso, .miso_oe,
        .bias_trim, .trim_x_enable, .trim_y_enable, .pulses_per_turn, .index_shape, .pole_pair_count,
        .field_too_high_flag, .field_too_low_flag, .commit_busy, .config_ready);
    spi_master_model spi_master_model_inst (.sys_clk, .miso, .sclk, .cs_n, .mosi);
    ////////////////////////////////////////
    task automatic test_done;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // bounded wait for reload and commit to finish
    task automatic wait_idle;
        int k = 0;
        while ((commit_busy !== 1'b0 || config_ready !== 1'b1) && k < 400) begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 400) begin
            n_errors++;
            test_done();
        end
    endtask
    task automatic do_reset(input logic erase);
        srst <= 1'b1;
        factory_erase <= erase;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        factory_erase <= 1'b0;
        wait_idle();
    endtask
    task automatic send(input logic [15:0] cmd);
        spi_master_model_inst.frame(cmd, 1'b0, rsp);
    endtask
    // frame whose answer is known, parity included
    task automatic xfer(input logic [15:0] cmd, input logic idle_hi, input logic [15:0] e);
        spi_master_model_inst.frame(cmd, idle_hi, rsp);
        `CHECK(rsp, {e, ^e})
    endtask
    ////////////////////////////////////////
    initial begin
        do_reset(1'b1);
        for (int r = 0; r < 10; r++) begin
            send({sensor_cfg_pkg::OP_READ, row_addr[r], 8'h00});
            xfer(16'h0000, 1'b0, {row_dflt[r], 8'h00});
            send({sensor_cfg_pkg::OP_WRITE, row_addr[r], row_data[r]});
            wait_idle();
            xfer(16'h0000, 1'b0, {row_back[r], 8'h00});
        end
        `CHECK(bias_trim, 8'ha5)
        `CHECK({trim_y_enable, trim_x_enable}, 2'h3)
        `CHECK(pulses_per_turn, 8'hfd)
        `CHECK(index_shape, 4'h6)
        `CHECK(pole_pair_count, 3'h7)
        // idle-high clock, reversed direction plus offset f1c7
        xfer(16'h0000, 1'b1, 16'hdf93);
        // next frame too early: old value comes back
        send({sensor_cfg_pkg::OP_WRITE, 5'h02, 8'h5a});
        xfer(16'h0000, 1'b0, 16'ha500);
        wait_idle();
        send({sensor_cfg_pkg::OP_READ, 5'h02, 8'h00});
        xfer(16'h0000, 1'b0, 16'h5a00);
        // flag register ignores writes
        send({sensor_cfg_pkg::OP_WRITE, sensor_cfg_pkg::ADDR_FIELD_FLAGS, 8'hff});
        `CHECK(commit_busy, 1'b0)
        xfer(16'h0000, 1'b0, 16'h4000);
        field_mt <= 8'hff;
        repeat (4) @(posedge sys_clk);
        `CHECK(field_too_high_flag, 1'b1)
        send({sensor_cfg_pkg::OP_READ, sensor_cfg_pkg::ADDR_FIELD_FLAGS, 8'h00});
        xfer(16'h0000, 1'b0, 16'h8000);
        // stored image survives a reset without erase
        do_reset(1'b0);
        `CHECK(bias_trim, 8'h5a)
        test_done();
    end
endmodule

// ===== rtl/angle_sensor_config_regs.sv
/*
 * configuration register bank of a magnetic angle sensor behind a serial slave
 * assumes raw_angle and field_mt come from front-end logic on sys_clk,
 * serial pins come from outside and are synchronised in the shifter
 */
`timescale 1ns/1ps
module angle_sensor_config_regs #(
    parameter int unsigned COMMIT_CYCLES = sensor_cfg_pkg::NVM_COMMIT_CYCLES
) (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    input  wire logic         sclk,
    input  wire logic         cs_n,
    input  wire logic         mosi,
    input  wire logic         factory_erase,
    input  wire logic [15:0]  raw_angle,
    input  wire logic [7:0]   field_mt,
    output logic              miso,
    output logic              miso_oe,
    output logic      [7:0]   bias_trim,
    output logic              trim_x_enable,
    output logic              trim_y_enable,
    output logic      [7:0]   pulses_per_turn,
    output logic      [3:0]   index_shape,
    output logic      [2:0]   pole_pair_count,
    output logic              field_too_high_flag,
    output logic              field_too_low_flag,
    output logic              commit_busy,
    output logic              config_ready
);

    ////////////////////////////////////////////////////////////////////////////

    typedef enum logic {
        PHASE_LOAD,
        PHASE_RUN
    } phase_t;

    typedef enum logic {
        RESP_ANGLE,
        RESP_REG
    } resp_t;

    typedef struct packed {
        phase_t          phase;
        logic [3:0]      load_index;
        logic [9:0][7:0] regs;
        resp_t           resp_kind;
        logic [4:0]      resp_addr;
        logic            flag_high;
        logic            flag_low;
        logic            erase_s1;
        logic            erase_s2;
        logic            nvm_wr;
        logic [3:0]      nvm_index;
        logic [7:0]      nvm_data;
    } core_state_t;

    core_state_t s;
    core_state_t next_s;

    spi_frame_if frame ();

    logic [7:0]  nvm_rd_data;
    logic        nvm_busy;
    logic        nvm_done;
    logic [3:0]  nvm_done_index;
    logic [7:0]  nvm_done_data;

    logic [2:0]  rx_opcode;
    logic [4:0]  rx_addr;
    logic [7:0]  rx_value;
    logic [2:0]  low_code;
    logic [2:0]  high_code;
    logic [7:0]  low_rise;
    logic [7:0]  high_rise;
    logic [15:0] zero_offset;
    logic [15:0] directed_angle;
    logic [15:0] streamed_angle;

    ////////////////////////////////////////////////////////////////////////////

    // address 8 is a hole in the map
    function automatic logic is_programmable(input logic [4:0] addr);
        is_programmable = (addr <= {1'b0, sensor_cfg_pkg::LAST_PROG_INDEX})
                       && (addr != sensor_cfg_pkg::ADDR_GAP);
    endfunction

    function automatic logic [7:0] read_reg(input logic [9:0][7:0] regs,
                                            input logic [4:0]      addr,
                                            input logic            hi,
                                            input logic            lo);
        read_reg = 8'h00;
        if (is_programmable(addr)) begin
            read_reg = regs[addr[3:0]] & sensor_cfg_pkg::REG_MASK[addr[3:0]];
        end else if (addr == sensor_cfg_pkg::ADDR_FIELD_FLAGS) begin
            read_reg = {hi, lo, 6'h00};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    spi_frame_shifter u_shifter (
        .sys_clk (sys_clk),
        .srst    (srst),
        .sclk    (sclk),
        .cs_n    (cs_n),
        .mosi    (mosi),
        .miso    (miso),
        .miso_oe (miso_oe),
        .frame   (frame.shifter)
    );

    nvm_config_store #(
        .COMMIT_CYCLES (COMMIT_CYCLES)
    ) u_nvm (
        .sys_clk      (sys_clk),
        .srst         (srst),
        .erase        (srst && s.erase_s2),
        .wr_en        (s.nvm_wr),
        .wr_index     (s.nvm_index),
        .wr_data      (s.nvm_data),
        .rd_index     (s.load_index),
        .rd_data      (nvm_rd_data),
        .busy         (nvm_busy),
        .commit_done  (nvm_done),
        .commit_index (nvm_done_index),
        .commit_data  (nvm_done_data)
    );

    ////////////////////////////////////////////////////////////////////////////

    // command fields, msb first on the wire
    assign rx_opcode = frame.rx_word[15:13];
    assign rx_addr   = frame.rx_word[12:8];
    assign rx_value  = frame.rx_word[7:0];

    assign low_code  = s.regs[sensor_cfg_pkg::ADDR_FIELD_THRESH[3:0]][7:5];
    assign high_code = s.regs[sensor_cfg_pkg::ADDR_FIELD_THRESH[3:0]][4:2];
    assign low_rise  = sensor_cfg_pkg::FIELD_RISE_MT[low_code];
    assign high_rise = sensor_cfg_pkg::FIELD_RISE_MT[high_code];

    assign zero_offset = {s.regs[sensor_cfg_pkg::ADDR_ZERO_HIGH[3:0]],
                          s.regs[sensor_cfg_pkg::ADDR_ZERO_LOW[3:0]]};

    // counterclockwise sense is the negated raw angle
    assign directed_angle = s.regs[sensor_cfg_pkg::ADDR_DIRECTION[3:0]][sensor_cfg_pkg::DIR_BIT]
                          ? 16'h0000 - raw_angle : raw_angle;
    // raw minus reference equals raw plus offset, wrapping at 16 bits
    assign streamed_angle = directed_angle + zero_offset;

    // answer word is picked before select and frozen by the shifter
    assign frame.tx_word = (s.resp_kind == RESP_REG)
                         ? {read_reg(s.regs, s.resp_addr, s.flag_high, s.flag_low), 8'h00}
                         : streamed_angle;

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_s        = s;
        next_s.nvm_wr = 1'b0;

        // field comparators with hysteresis below each rising level
        if (field_mt > high_rise) begin
            next_s.flag_high = 1'b1;
        end else if (field_mt < high_rise - sensor_cfg_pkg::FIELD_HYST_MT) begin
            next_s.flag_high = 1'b0;
        end
        if (field_mt < low_rise - sensor_cfg_pkg::FIELD_HYST_MT) begin
            next_s.flag_low = 1'b1;
        end else if (field_mt > low_rise) begin
            next_s.flag_low = 1'b0;
        end

        unique case (s.phase)
            PHASE_LOAD: begin
                // walk the stored image back into the working copy
                next_s.regs[s.load_index] = nvm_rd_data
                                          & sensor_cfg_pkg::REG_MASK[s.load_index];
                if (s.load_index == sensor_cfg_pkg::LAST_PROG_INDEX) begin
                    next_s.phase = PHASE_RUN;
                end else begin
                    next_s.load_index = s.load_index + 4'h1;
                end
            end
            PHASE_RUN: begin
                // working copy only moves once the commit ends
                if (nvm_done) begin
                    next_s.regs[nvm_done_index] = nvm_done_data;
                end
            end
        endcase

        // the answer serves only the frame right after the request
        if (frame.frame_start) begin
            next_s.resp_kind = RESP_ANGLE;
        end

        if (frame.frame_done) begin
            if (rx_opcode == sensor_cfg_pkg::OP_WRITE) begin
                next_s.resp_kind = RESP_REG;
                next_s.resp_addr = rx_addr;
                // read-only and unmapped targets never reach the store
                if (is_programmable(rx_addr) && !nvm_busy) begin
                    next_s.nvm_wr    = 1'b1;
                    next_s.nvm_index = rx_addr[3:0];
                    next_s.nvm_data  = rx_value & sensor_cfg_pkg::REG_MASK[rx_addr[3:0]];
                end
            end else if (rx_opcode == sensor_cfg_pkg::OP_READ) begin
                next_s.resp_kind = RESP_REG;
                next_s.resp_addr = rx_addr;
            end else begin
                next_s.resp_kind = RESP_ANGLE;
            end
        end

        next_s.erase_s1 = factory_erase;
        next_s.erase_s2 = s.erase_s1;

        if (srst) begin
            next_s.phase      = PHASE_LOAD;
            next_s.load_index = 4'h0;
            next_s.regs       = sensor_cfg_pkg::REG_RESET;
            next_s.resp_kind  = RESP_ANGLE;
            next_s.resp_addr  = 5'h00;
            next_s.flag_high  = 1'b0;
            next_s.flag_low   = 1'b0;
            next_s.nvm_wr     = 1'b0;
            next_s.nvm_index  = 4'h0;
            next_s.nvm_data   = 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////////////

    assign bias_trim           = s.regs[sensor_cfg_pkg::ADDR_BIAS_TRIM[3:0]];
    assign trim_x_enable       = s.regs[sensor_cfg_pkg::ADDR_TRIM_AXIS[3:0]][sensor_cfg_pkg::TRIM_X_BIT];
    assign trim_y_enable       = s.regs[sensor_cfg_pkg::ADDR_TRIM_AXIS[3:0]][sensor_cfg_pkg::TRIM_Y_BIT];
    assign pulses_per_turn     = {s.regs[sensor_cfg_pkg::ADDR_PULSES_UPPER[3:0]][5:0],
                                  s.regs[sensor_cfg_pkg::ADDR_PULSES_INDEX[3:0]][7:6]};
    assign index_shape         = s.regs[sensor_cfg_pkg::ADDR_PULSES_INDEX[3:0]][5:2];
    assign pole_pair_count     = s.regs[sensor_cfg_pkg::ADDR_POLE_PAIRS[3:0]][7:5];
    assign field_too_high_flag = s.flag_high;
    assign field_too_low_flag  = s.flag_low;
    assign commit_busy         = nvm_busy;
    assign config_ready        = (s.phase == PHASE_RUN);

endmodule

// ===== rtl/nvm_config_store.sv
/*
 * non-volatile image of the programmable registers with commit timer
 * assumes erase is only raised by the core during reset
 */
`timescale 1ns/1ps
module nvm_config_store #(
    parameter int unsigned COMMIT_CYCLES = sensor_cfg_pkg::NVM_COMMIT_CYCLES
) (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    input  wire logic         erase,
    input  wire logic         wr_en,
    input  wire logic [3:0]   wr_index,
    input  wire logic [7:0]   wr_data,
    input  wire logic [3:0]   rd_index,
    output logic      [7:0]   rd_data,
    output logic              busy,
    output logic              commit_done,
    output logic      [3:0]   commit_index,
    output logic      [7:0]   commit_data
);
    typedef struct packed {
        logic        busy;
        logic        done;
        logic [31:0] count;
        logic [3:0]  index;
        logic [7:0]  data;
    } nvm_state_t;

    nvm_state_t s;
    nvm_state_t next_s;
    // contents survive srst: no reset on the cells
    logic [7:0] cells [0:9];

    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        if (s.busy) begin
            if (s.count == 32'h0000_0000) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end else begin
                next_s.count = s.count - 32'h0000_0001;
            end
        end else if (wr_en) begin
            // a write during a commit is dropped
            next_s.busy  = 1'b1;
            next_s.count = COMMIT_CYCLES - 32'h0000_0001;
            next_s.index = wr_index;
            next_s.data  = wr_data;
        end
        if (srst) begin
            next_s = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        s <= next_s;
    end

    always_ff @(posedge sys_clk) begin
        if (erase) begin
            for (int i = 0; i < 10; i++) begin
                cells[i] <= sensor_cfg_pkg::REG_RESET[i];
            end
        end else if (s.busy && s.count == 32'h0000_0000) begin
            cells[s.index] <= s.data;
        end
    end

    assign rd_data      = (rd_index <= sensor_cfg_pkg::LAST_PROG_INDEX) ? cells[rd_index] : 8'h00;
    assign busy         = s.busy;
    assign commit_done  = s.done;
    assign commit_index = s.index;
    assign commit_data  = s.data;
endmodule

// ===== rtl/sensor_cfg_pkg.sv
/*
 * constants for the angle sensor configuration bank: map, resets, masks
 * assumes a 10 MHz system clock
 */
package sensor_cfg_pkg;

    localparam int unsigned SYS_CLK_HZ        = 10_000_000;
    localparam int unsigned NVM_COMMIT_MS     = 20;
    localparam int unsigned NVM_COMMIT_CYCLES = NVM_COMMIT_MS * (SYS_CLK_HZ / 1000);

    localparam logic [2:0] OP_WRITE = 3'h4;
    localparam logic [2:0] OP_READ  = 3'h2;

    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] COUNT_MAX  = 5'h1f;

    localparam logic [4:0] ADDR_ZERO_LOW       = 5'h00;
    localparam logic [4:0] ADDR_ZERO_HIGH      = 5'h01;
    localparam logic [4:0] ADDR_BIAS_TRIM      = 5'h02;
    localparam logic [4:0] ADDR_TRIM_AXIS      = 5'h03;
    localparam logic [4:0] ADDR_PULSES_INDEX   = 5'h04;
    localparam logic [4:0] ADDR_PULSES_UPPER   = 5'h05;
    localparam logic [4:0] ADDR_FIELD_THRESH   = 5'h06;
    localparam logic [4:0] ADDR_POLE_PAIRS     = 5'h07;
    localparam logic [4:0] ADDR_GAP            = 5'h08;
    localparam logic [4:0] ADDR_DIRECTION      = 5'h09;
    localparam logic [4:0] ADDR_FIELD_FLAGS    = 5'h1b;
    localparam logic [3:0] LAST_PROG_INDEX     = 4'h9;

    // index 9 leftmost
    localparam logic [9:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h00, 8'h1c, 8'h3f,
                                             8'hc0, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [9:0][7:0] REG_MASK  = {8'h80, 8'h00, 8'he0, 8'hfc, 8'h3f,
                                             8'hfc, 8'h03, 8'hff, 8'hff, 8'hff};

    localparam int unsigned DIR_BIT       = 7;
    localparam int unsigned TRIM_X_BIT    = 0;
    localparam int unsigned TRIM_Y_BIT    = 1;

    // rising thresholds in mT, falling is rise minus hysteresis
    localparam logic [7:0][7:0] FIELD_RISE_MT = {8'h7e, 8'h70, 8'h62, 8'h54,
                                                 8'h46, 8'h38, 8'h29, 8'h1a};
    localparam logic [7:0]      FIELD_HYST_MT = 8'h06;

endpackage

// ===== rtl/spi_frame_if.sv
/*
 * frame hand-off between the serial shifter and the register core
 * assumes both ends share sys_clk
 */
`timescale 1ns/1ps
interface spi_frame_if;
    logic        frame_start;
    logic        frame_done;
    logic [15:0] rx_word;
    logic [15:0] tx_word;

    modport shifter (input tx_word, output frame_start, output frame_done, output rx_word);
    modport core    (output tx_word, input frame_start, input frame_done, input rx_word);
endinterface

// ===== rtl/spi_frame_shifter.sv
/*
 * serial slave shifter: syncs pins, auto mode 0/3, 16 bits plus parity
 * assumes sclk far slower than sys_clk (at least 4 clocks per half period)
 */
`timescale 1ns/1ps
module spi_frame_shifter (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    input  wire logic         sclk,
    input  wire logic         cs_n,
    input  wire logic         mosi,
    output logic              miso,
    output logic              miso_oe,
    spi_frame_if.shifter      frame
);
    typedef struct packed {
        logic [2:0]  sclk_q;
        logic [2:0]  cs_q;
        logic [1:0]  mosi_q;
        logic        seen_rise;
        logic [4:0]  count;
        logic [15:0] rx;
        logic [16:0] tx;
        logic        miso;
        logic        miso_oe;
        logic        start;
        logic        done;
        logic [15:0] rx_word;
    } shift_state_t;

    shift_state_t s;
    shift_state_t next_s;

    always_comb begin
        next_s        = s;
        next_s.start  = 1'b0;
        next_s.done   = 1'b0;
        next_s.sclk_q = {s.sclk_q[1:0], sclk};
        next_s.cs_q   = {s.cs_q[1:0], cs_n};
        next_s.mosi_q = {s.mosi_q[0], mosi};
        if (!s.cs_q[1] && s.cs_q[2]) begin
            // freeze the answer at select
            next_s.tx        = {frame.tx_word, ^frame.tx_word};
            next_s.miso      = frame.tx_word[15];
            next_s.miso_oe   = 1'b1;
            next_s.count     = 5'h00;
            next_s.seen_rise = 1'b0;
            next_s.start     = 1'b1;
        end else if (!s.cs_q[1]) begin
            if (s.sclk_q[1] && !s.sclk_q[2]) begin
                // bits past the sixteenth are parity clocks, not data
                if (s.count < sensor_cfg_pkg::FRAME_BITS) begin
                    next_s.rx = {s.rx[14:0], s.mosi_q[1]};
                end
                if (s.count != sensor_cfg_pkg::COUNT_MAX) begin
                    next_s.count = s.count + 5'h01;
                end
                next_s.seen_rise = 1'b1;
            end
            // mode 3 opens with a falling edge that must not shift
            if (!s.sclk_q[1] && s.sclk_q[2] && s.seen_rise) begin
                next_s.tx   = {s.tx[15:0], 1'b0};
                next_s.miso = s.tx[15];
            end
        end
        if (s.cs_q[1] && !s.cs_q[2]) begin
            next_s.miso_oe = 1'b0;
            next_s.miso    = 1'b0;
            if (s.count >= sensor_cfg_pkg::FRAME_BITS) begin
                next_s.done    = 1'b1;
                next_s.rx_word = s.rx;
            end
        end
        if (srst) begin
            next_s        = '0;
            next_s.cs_q   = 3'h7;
            next_s.sclk_q = {s.sclk_q[1:0], sclk};
        end
    end

    always_ff @(posedge sys_clk) begin
        s <= next_s;
    end

    assign miso              = s.miso;
    assign miso_oe           = s.miso_oe;
    assign frame.frame_start = s.start;
    assign frame.frame_done  = s.done;
    assign frame.rx_word     = s.rx_word;
endmodule
